//--- hdl/dpr_host.sv
// Host end: AXI4-Lite controller, bus sequencer and output demultiplexer
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
// What this block does
// - Reset leaves interrupt high, ready to convert
// - Reset mode is bank A, one channel
// - Host waits reset time before converting
// - Result memory undefined until first sequence
// - Power-down bit set enters power-down at once
// - Power-down stops converter, bus stays alive
// - Write with power-down clear wakes into mode
// - Host waits wake delay before converting
// - Results are twos-complement words
// - Demux uses 16 MHz tick and interrupt
// - Chip select low across whole read burst
// - Two-bit select picks channel to latch
// - Control bits latched at write or select end
// - Interrupt falls at end, first read raises it
// - Read pointer advances, wraps after last channel
// - Bit two picks bank B; low bits count
module dpr_host import dpr_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Parallel bus
  dpr_bus_if.host bus,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    dpr_host_state_type st;
    logic [CNT_W-1:0] cnt;
    logic [NCH_W-1:0] idx;
    logic cs_n, wr_n, rd_n, conv_n, oe_n, int_s;
    logic [DATA_W-1:0] dout;
    logic [CTRL_W-1:0] ctrl;
    logic [NCH_W-1:0] sel;
    logic [DATA_W-1:0] word;
    logic word_valid;
    logic awready, wready, have_aw, have_w, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] waddr;
    logic [CTRL_W-1:0] wd;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } dpr_host_type;

  localparam dpr_host_type HOST_RESET = '{
    st: HST_SETTLE, cnt: RESET_COUNT, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
    conv_n: 1'b1, oe_n: 1'b1, int_s: 1'b1, awready: 1'b1, wready: 1'b1,
    arready: 1'b1, ctrl: CTRL_RESET, default: '0
  };

  dpr_host_type r, next_r;
  logic tick;
  logic idle;

  dpr_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  always_comb begin
    next_r = r;
    next_r.int_s = bus.int_n;
    idle = (r.st == HST_IDLE);
    case (r.st)
      HST_SETTLE: begin
        if (r.cnt == '0) begin
          next_r.st = HST_IDLE;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      HST_WRITE: begin
        if (tick) begin
          next_r.cs_n = 1'b1;
          next_r.wr_n = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.cnt = WAKE_COUNT;
          next_r.st = HST_SETTLE;
        end
      end
      HST_CONV: begin
        if (tick) begin
          next_r.conv_n = 1'b1;
          next_r.st = HST_WAIT_INT;
        end
      end
      HST_WAIT_INT: begin
        if (tick && !r.int_s) begin
          next_r.cs_n = 1'b0;
          next_r.rd_n = 1'b0;
          next_r.idx = '0;
          next_r.st = HST_RD_LOW;
        end
      end
      HST_RD_LOW: begin
        if (tick) begin
          next_r.rd_n = 1'b1;
          if (r.idx == r.sel) begin
            next_r.word = bus.data;
            next_r.word_valid = 1'b1;
          end
          next_r.st = HST_RD_HIGH;
        end
      end
      HST_RD_HIGH: begin
        if (tick) begin
          if (r.idx == LAST_CH) begin
            next_r.cs_n = 1'b1;
            next_r.st = HST_IDLE;
          end else begin
            next_r.idx = r.idx + 1'b1;
            next_r.rd_n = 1'b0;
            next_r.st = HST_RD_LOW;
          end
        end
      end
      HST_IDLE: begin
      end
      default: begin
        next_r.st = HST_IDLE;
      end
    endcase

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && r.awready) begin
      next_r.awready = 1'b0;
      next_r.have_aw = 1'b1;
      next_r.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.wready = 1'b0;
      next_r.have_w = 1'b1;
      next_r.wd = s_axi_wdata[CTRL_W-1:0];
    end
    if (r.have_aw && r.have_w && !r.bvalid) begin
      next_r.have_aw = 1'b0;
      next_r.have_w = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = AXI_OKAY;
      case (r.waddr)
        REG_CONTROL: begin
          if (idle) begin
            next_r.ctrl = r.wd;
            next_r.dout = {{(DATA_W - CTRL_W){1'b0}}, r.wd};
            next_r.cs_n = 1'b0;
            next_r.wr_n = 1'b0;
            next_r.oe_n = 1'b0;
            next_r.st = HST_WRITE;
          end else begin
            next_r.bresp = AXI_SLVERR;
          end
        end
        REG_CONVERT: begin
          if (idle) begin
            next_r.conv_n = 1'b0;
            next_r.word_valid = 1'b0;
            next_r.st = HST_CONV;
          end else begin
            next_r.bresp = AXI_SLVERR;
          end
        end
        REG_SELECT: begin
          next_r.sel = r.wd[NCH_W-1:0];
        end
        default: begin
          next_r.bresp = AXI_SLVERR;
        end
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = AXI_OKAY;
      next_r.rdata = '0;
      case (s_axi_araddr)
        REG_CONTROL: next_r.rdata[CTRL_W-1:0] = r.ctrl;
        REG_CONVERT: next_r.rdata = '0;
        REG_SELECT: next_r.rdata[NCH_W-1:0] = r.sel;
        REG_STATUS: begin
          next_r.rdata[STAT_BUSY_BIT] = !idle;
          next_r.rdata[STAT_VALID_BIT] = r.word_valid;
          next_r.rdata[STAT_INT_BIT] = r.int_s;
        end
        REG_DATA: next_r.rdata[DATA_W-1:0] = r.word;
        default: next_r.rresp = AXI_SLVERR;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= HOST_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign bus.cs_n = r.cs_n;
  assign bus.wr_n = r.wr_n;
  assign bus.rd_n = r.rd_n;
  assign bus.convert_request_n = r.conv_n;
  assign bus.host_data_out = r.dout;
  assign bus.host_data_oe_n = r.oe_n;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
endmodule

//--- hdl/dpr_pkg.sv
// Shared constants and types for the converter control and readout demultiplexer
package dpr_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SYS_CLK_MHZ = 200;
  localparam int LINK_CLK_MHZ = 16;
  localparam int RESET_TIME_NS = 5000;
  localparam int WAKE_TIME_NS = 5000;
  localparam int CONV_TIME_NS = 3000;
  localparam int CNT_W = 10;
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] RESET_COUNT = CNT_W'(RESET_CYCLES - 1);
  localparam logic [CNT_W-1:0] WAKE_COUNT = CNT_W'(WAKE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CONV_COUNT = CNT_W'(CONV_CYCLES - 1);
  localparam int TICK_W = 8;
  localparam logic [TICK_W:0] TICK_STEP = (TICK_W + 1)'(LINK_CLK_MHZ);
  localparam logic [TICK_W:0] TICK_MOD = (TICK_W + 1)'(SYS_CLK_MHZ);

  // Data bus and control word layout
  localparam int DATA_W = 14;
  localparam int NCH = 4;
  localparam int CTRL_W = 4;
  localparam int CTRL_PD_BIT = 3;
  localparam int CTRL_BANK_BIT = 2;
  localparam int CTRL_NCH_LSB = 0;
  localparam int NCH_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
  localparam logic [NCH_W-1:0] LAST_CH = 2'h3;

  // Controller registers on AXI4-Lite
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CONVERT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SELECT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DATA = 8'h10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_INT_BIT = 2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [0:0] {DEV_IDLE, DEV_CONV} dpr_dev_state_type;
  typedef enum logic [2:0] {
    HST_SETTLE, HST_IDLE, HST_WRITE, HST_CONV, HST_WAIT_INT, HST_RD_LOW, HST_RD_HIGH
  } dpr_host_state_type;
endpackage

//--- hdl/dpr_bus_if.sv
// Parallel bus between the converter and its host controller
`timescale 1ns/100ps
interface dpr_bus_if import dpr_pkg::*; ();
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic convert_request_n;
  logic int_n;
  logic [DATA_W-1:0] dev_data_out;
  logic dev_data_oe_n;
  logic [DATA_W-1:0] host_data_out;
  logic host_data_oe_n;
  logic [DATA_W-1:0] data;

  // Wire level: the active driver wins, an idle bus reads as zero
  assign data = !dev_data_oe_n ? dev_data_out :
                !host_data_oe_n ? host_data_out : '0;

  modport dev (
    input cs_n, wr_n, rd_n, convert_request_n, data,
    output int_n, dev_data_out, dev_data_oe_n
  );
  modport host (
    input int_n, data,
    output cs_n, wr_n, rd_n, convert_request_n, host_data_out, host_data_oe_n
  );
endinterface

//--- hdl/dpr_tick_gen.sv
// Fractional divider giving a one-cycle enable at the 16 MHz link rate
`timescale 1ns/100ps
module dpr_tick_gen import dpr_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Enable out
  output logic tick
);
  typedef struct packed {
    logic [TICK_W:0] phase;
    logic tick;
  } dpr_tick_type;

  dpr_tick_type r, next_r;
  logic [TICK_W:0] sum;

  always_comb begin
    next_r = r;
    sum = r.phase + TICK_STEP;
    next_r.tick = 1'b0;
    if (sum >= TICK_MOD) begin
      sum = sum - TICK_MOD;
      next_r.tick = 1'b1;
    end
    next_r.phase = sum;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule

//--- hdl/dpr_device.sv
// Converter end: control word, power state, conversion sequencer and readout
`timescale 1ns/100ps
module dpr_device import dpr_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Parallel bus
  dpr_bus_if.dev bus,
  // Sampled inputs, twos-complement, one word per channel
  input wire logic [NCH-1:0][DATA_W-1:0] bank_a_in,
  input wire logic [NCH-1:0][DATA_W-1:0] bank_b_in,
  // Status
  output logic powered_down,
  output logic converting,
  output logic bank_b_selected,
  output logic [NCH_W-1:0] channels_minus_one
);
  typedef struct packed {
    dpr_dev_state_type st;
    logic [CTRL_W-1:0] ctrl_hold;
    logic wr_act;
    logic rd_act;
    logic conv_n_d;
    logic pd;
    logic bank_b;
    logic [NCH_W-1:0] nch_m1;
    logic [NCH_W-1:0] conv_idx;
    logic [CNT_W-1:0] tcount;
    logic [NCH_W-1:0] rd_ptr;
    logic int_n;
    logic [DATA_W-1:0] dout;
    logic oe_n;
    logic [NCH-1:0][DATA_W-1:0] hold;
    logic [NCH-1:0][DATA_W-1:0] mem;
  } dpr_dev_type;

  // Memory content is cleared only for a defined start, software must not rely on it
  localparam dpr_dev_type DEV_RESET = '{
    st: DEV_IDLE,
    ctrl_hold: CTRL_RESET,
    wr_act: 1'b0,
    rd_act: 1'b0,
    conv_n_d: 1'b1,
    pd: 1'b0,
    bank_b: 1'b0,
    nch_m1: '0,
    conv_idx: '0,
    tcount: '0,
    rd_ptr: '0,
    int_n: 1'b1,
    dout: '0,
    oe_n: 1'b1,
    hold: '0,
    mem: '0
  };

  dpr_dev_type r, next_r;
  logic wr_act;
  logic rd_act;

  always_comb begin
    next_r = r;
    wr_act = !bus.cs_n && !bus.wr_n;
    rd_act = !bus.cs_n && !bus.rd_n;
    next_r.wr_act = wr_act;
    next_r.rd_act = rd_act;
    next_r.conv_n_d = bus.convert_request_n;

    // Control word capture; the bus value of the last active cycle is kept
    if (wr_act) begin
      next_r.ctrl_hold = bus.data[CTRL_W-1:0];
    end
    if (r.wr_act && !wr_act) begin
      if (r.ctrl_hold[CTRL_PD_BIT]) begin
        next_r.pd = 1'b1;
        next_r.st = DEV_IDLE;
      end else begin
        next_r.pd = 1'b0;
        next_r.bank_b = r.ctrl_hold[CTRL_BANK_BIT];
        next_r.nch_m1 = r.ctrl_hold[CTRL_NCH_LSB +: NCH_W];
      end
    end

    // Readout works in every power state
    if (rd_act && !r.rd_act) begin
      next_r.int_n = 1'b1;
      next_r.dout = r.mem[r.rd_ptr];
      next_r.oe_n = 1'b0;
    end
    if (!rd_act) begin
      next_r.oe_n = 1'b1;
    end
    if (r.rd_act && !rd_act) begin
      if (r.rd_ptr == r.nch_m1) begin
        next_r.rd_ptr = '0;
      end else begin
        next_r.rd_ptr = r.rd_ptr + 1'b1;
      end
    end

    // Sequencer; requests during a sequence or in power-down are ignored
    case (r.st)
      DEV_IDLE: begin
        if (!r.pd && !r.conv_n_d && bus.convert_request_n) begin
          next_r.hold = r.bank_b ? bank_b_in : bank_a_in;
          next_r.st = DEV_CONV;
          next_r.conv_idx = '0;
          next_r.tcount = CONV_COUNT;
        end
      end
      DEV_CONV: begin
        if (r.pd) begin
          next_r.st = DEV_IDLE;
        end else if (r.tcount != '0) begin
          next_r.tcount = r.tcount - 1'b1;
        end else begin
          next_r.mem[r.conv_idx] = r.hold[r.conv_idx];
          if (r.conv_idx == r.nch_m1) begin
            next_r.st = DEV_IDLE;
            next_r.int_n = 1'b0;
            next_r.rd_ptr = '0;
          end else begin
            next_r.conv_idx = r.conv_idx + 1'b1;
            next_r.tcount = CONV_COUNT;
          end
        end
      end
      default: begin
        next_r.st = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= DEV_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign bus.int_n = r.int_n;
  assign bus.dev_data_out = r.dout;
  assign bus.dev_data_oe_n = r.oe_n;
  assign powered_down = r.pd;
  assign converting = (r.st == DEV_CONV);
  assign bank_b_selected = r.bank_b;
  assign channels_minus_one = r.nch_m1;
endmodule

//--- verification/dpr_props.sv
// Concurrent checks on the parallel link between converter and host controller
`timescale 1ns/100ps
module dpr_props import dpr_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic convert_request_n,
  input wire logic int_n,
  input wire logic dev_data_oe_n,
  input wire logic host_data_oe_n
);
  logic [CNT_W-1:0] quiet;
  logic [4:0] low_len;
  logic [2:0] reads;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Idle time since reset or last write, read strobe low time, reads per select
  always_ff @(posedge aclk) begin
    if (!aresetn || !wr_n) begin
      quiet <= '0;
    end else if (quiet != '1) begin
      quiet <= quiet + 1'b1;
    end
    low_len <= rd_n ? 5'h0 : low_len + 5'h1;
    reads <= cs_n ? 3'h0 : reads + 3'($fell(rd_n));
  end

  sequence s_read_start;
    $fell(rd_n) && !cs_n;
  endsequence
  sequence s_word_out;
    !dev_data_oe_n && int_n;
  endsequence

  property p_reset_idle; $rose(aresetn) |-> int_n && dev_data_oe_n && cs_n; endproperty
  property p_read_answer; s_read_start |=> s_word_out; endproperty
  property p_release; $rose(rd_n) |-> ##[1:2] dev_data_oe_n; endproperty
  property p_read_cs; !rd_n |-> !cs_n; endproperty
  property p_burst; $rose(cs_n) |-> reads == 3'h0 || reads == 3'h4; endproperty
  property p_rd_len; $rose(rd_n) |-> low_len >= 5'h0c && low_len <= 5'h0d; endproperty
  property p_no_clash; !(!dev_data_oe_n && !host_data_oe_n); endproperty
  property p_write_drive; !wr_n |-> !cs_n && !host_data_oe_n && rd_n; endproperty
  property p_settle; $fell(convert_request_n) |-> quiet >= CNT_W'(WAKE_CYCLES); endproperty
  property p_int_quiet; $fell(int_n) |-> rd_n && cs_n; endproperty
  property p_int_clear; $rose(int_n) |-> !rd_n && !cs_n; endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_release: assert property (p_release) else $error("data bus not released");
  a_read_cs: assert property (p_read_cs) else $error("read without select");
  a_burst: assert property (p_burst) else $error("burst not four reads");
  a_rd_len: assert property (p_rd_len) else $error("read strobe length");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  a_write_drive: assert property (p_write_drive) else $error("write not framed");
  a_settle: assert property (p_settle) else $error("convert too early");
  a_int_quiet: assert property (p_int_quiet) else $error("end flag during access");
  a_int_clear: assert property (p_int_clear) else $error("end flag cleared without read");
endmodule

//--- verification/test_das_power_state_and_readout_demux.sv
// Self-checking bench joining converter and host controller
`timescale 1ns/100ps
`define CHK(n, e, g) \
  compares++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("wrong value %s exp %h got %h", n, e, g); \
  end
module test_das_power_state_and_readout_demux import dpr_pkg::*; ;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pd, bsel, conv;
  logic [1:0] bresp, rresp, rs, nm1;
  logic [NCH-1:0][DATA_W-1:0] bank_a, bank_b;
  int failures, compares;

  dpr_bus_if i_dpr_bus_if ();
  dpr_device i_dpr_device (.aclk(aclk), .aresetn(aresetn), .bus(i_dpr_bus_if),
    .bank_a_in(bank_a), .bank_b_in(bank_b), .powered_down(pd), .converting(conv),
    .bank_b_selected(bsel), .channels_minus_one(nm1));
  dpr_host i_dpr_host (.aclk(aclk), .aresetn(aresetn), .bus(i_dpr_bus_if),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  dpr_props i_dpr_props (.aclk(aclk), .aresetn(aresetn), .cs_n(i_dpr_bus_if.cs_n),
    .wr_n(i_dpr_bus_if.wr_n), .rd_n(i_dpr_bus_if.rd_n), .int_n(i_dpr_bus_if.int_n),
    .convert_request_n(i_dpr_bus_if.convert_request_n),
    .dev_data_oe_n(i_dpr_bus_if.dev_data_oe_n),
    .host_data_oe_n(i_dpr_bus_if.host_data_oe_n));

  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Poll status until the controller is free
  task automatic idle();
    int n;
    n = 0;
    do begin
      rdr(REG_STATUS);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    if (rd[STAT_BUSY_BIT] !== 1'b0) failures++;
  endtask

  // Pointer wraps after the programmed count, so select picks modulo count
  function automatic logic [DATA_W-1:0] expw(logic [3:0] m, logic [1:0] s);
    logic [NCH_W-1:0] ch;
    ch = NCH_W'(s % ({1'b0, m[1:0]} + 3'h1));
    return m[CTRL_BANK_BIT] ? bank_b[ch] : bank_a[ch];
  endfunction

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    #500_000;
    failures++;
    close_out();
  end

  initial begin
    logic [3:0] m;
    logic [1:0] s;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, bank_a, bank_b} = '0;
    void'($urandom(32'h91b0));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(REG_STATUS);
    `CHK("int", 1'b1, rd[STAT_INT_BIT])
    wr(REG_CONVERT, 32'h0);
    `CHK("early", AXI_SLVERR, rs)
    rdr(8'h40);
    `CHK("unmapped", AXI_SLVERR, rs)
    idle();
    `CHK("mode0", 4'h0, {pd, bsel, nm1})
    for (int i = 0; i < 8; i++) begin
      m = 4'(i);
      if (i == 7) begin
        wr(REG_CONTROL, {28'h0, 1'b1, 3'($urandom)});
        idle();
        `CHK("down", 1'b1, pd)
      end
      wr(REG_CONTROL, 32'(m));
      `CHK("okay", AXI_OKAY, rs)
      rdr(REG_CONTROL);
      `CHK("ctrl", m, rd[CTRL_W-1:0])
      idle();
      `CHK("mode", m, {pd, bsel, nm1})
      for (int k = 0; k < 2; k++) begin
        s = (k == 0) ? 2'h3 : 2'($urandom);
        for (int c = 0; c < NCH; c++) begin
          bank_a[c] <= (k == 0 && c == 0) ? 14'h2000 : DATA_W'($urandom);
          bank_b[c] <= DATA_W'($urandom);
        end
        wr(REG_SELECT, 32'(s));
        rdr(REG_SELECT);
        `CHK("sel", s, rd[NCH_W-1:0])
        wr(REG_CONVERT, 32'h0);
        repeat (16) @(posedge aclk);
        `CHK("conv", 1'b1, conv)
        idle();
        `CHK("valid", 1'b1, rd[STAT_VALID_BIT])
        `CHK("int_hi", 1'b1, rd[STAT_INT_BIT])
        rdr(REG_DATA);
        `CHK("word", expw(m, s), rd[DATA_W-1:0])
      end
    end
    // Reset again in mid-run: end flag and default mode must return
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(REG_STATUS);
    `CHK("int_rst", 1'b1, rd[STAT_INT_BIT])
    `CHK("mode_rst", 4'h0, {pd, bsel, nm1})
    close_out();
  end
endmodule
